// file: mrp_pkg.sv
// Package: constants and types for the 16-bit mouse report packer
// Contract
// - Three buttons: L,R,M in bits 0-2
// - Five buttons add back bit3, forward bit4
// - Byte 2 carries X bits 7..0
// - Byte 3 carries X bits 15..8
// - Byte 4 carries Y bits 7..0
// - Byte 5 carries Y bits 15..8
// - Byte 6 carries wheel count
// - Tilt enabled: seventh byte carries tilt count
// - Tilt disabled: six bytes, no tilt
package mrp_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_STATUS     = 8'h04;
	localparam logic [7:0]  REG_WORD0      = 8'h08;
	localparam logic [7:0]  REG_WORD1      = 8'h0C;
	localparam int          CTRL_TILT_BIT  = 0;
	localparam int          CTRL_FIVE_BIT  = 1;
	localparam int          CTRL_ARM_BIT   = 2;
	localparam logic [2:0]  CTRL_RESET     = 3'h0;
	localparam logic [1:0]  RESP_OKAY      = 2'b00;
	localparam logic [1:0]  RESP_SLVERR    = 2'b10;

	// ****************************************************************
	// Report layout
	// ****************************************************************
	localparam logic [2:0]  LEN_NO_TILT    = 3'd6;
	localparam logic [2:0]  LEN_TILT       = 3'd7;
	localparam int          BYTE_BUTTONS   = 0;
	localparam int          BYTE_X_LO      = 1;
	localparam int          BYTE_X_HI      = 2;
	localparam int          BYTE_Y_LO      = 3;
	localparam int          BYTE_Y_HI      = 4;
	localparam int          BYTE_WHEEL     = 5;
	localparam int          BYTE_TILT      = 6;
	localparam logic [2:0]  LAST_IDX_TILT  = 3'd6;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01
	} mrp_state_e;

	// Saturating signed add keeps a large move from wrapping to the opposite sign
	function automatic logic [15:0] sat_add16(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {a[15], a} + {b[15], b};
		if (s[16] != s[15]) begin
			sat_add16 = s[16] ? 16'h8000 : 16'h7FFF;
		end else begin
			sat_add16 = s[15:0];
		end
	endfunction : sat_add16

	function automatic logic [7:0] sat_add8(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {a[7], a} + {b[7], b};
		if (s[8] != s[7]) begin
			sat_add8 = s[8] ? 8'h80 : 8'h7F;
		end else begin
			sat_add8 = s[7:0];
		end
	endfunction : sat_add8
endpackage : mrp_pkg

// file: mrp_accum.sv
// Module: motion accumulator holding signed counts since the last report
`timescale 1ns/1ns
module mrp_accum
	import mrp_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        delta_valid,
	input  wire logic [15:0] delta_x,
	input  wire logic [15:0] delta_y,
	input  wire logic [7:0]  delta_wheel,
	input  wire logic [7:0]  delta_tilt,
	input  wire logic        snap,
	output logic      [15:0] acc_x,
	output logic      [15:0] acc_y,
	output logic      [7:0]  acc_wheel,
	output logic      [7:0]  acc_tilt
);
	logic [15:0] x_q, x_d, y_q, y_d;
	logic [7:0]  w_q, w_d, t_q, t_d;

	// Snap hands the totals out and restarts from any delta of the same cycle
	always_comb begin
		x_d = x_q;
		y_d = y_q;
		w_d = w_q;
		t_d = t_q;
		if (snap) begin
			x_d = '0;
			y_d = '0;
			w_d = '0;
			t_d = '0;
		end
		if (delta_valid) begin
			x_d = sat_add16(x_d, delta_x);
			y_d = sat_add16(y_d, delta_y);
			w_d = sat_add8(w_d, delta_wheel);
			t_d = sat_add8(t_d, delta_tilt);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			x_q <= '0;
			y_q <= '0;
			w_q <= '0;
			t_q <= '0;
		end else begin
			x_q <= x_d;
			y_q <= y_d;
			w_q <= w_d;
			t_q <= t_d;
		end
	end

	assign acc_x     = x_q;
	assign acc_y     = y_q;
	assign acc_wheel = w_q;
	assign acc_tilt  = t_q;
endmodule : mrp_accum

// file: mrp_axil.sv
// Module: AXI4-Lite register slave for the report packer
`timescale 1ns/1ns
module mrp_axil
	import mrp_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic      [2:0]  ctrl,
	input  wire logic [31:0] status,
	input  wire logic [31:0] word0,
	input  wire logic [31:0] word1
);
	logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
	logic [7:0]  awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0]  ws_q, ws_d;
	logic [1:0]  br_q, br_d, rr_q, rr_d;
	logic [2:0]  ctrl_q, ctrl_d;

	// Address and data are caught independently, in either order
	always_comb begin
		aw_d = aw_q;
		w_d = w_q;
		b_d = b_q;
		awa_d = awa_q;
		wd_d = wd_q;
		ws_d = ws_q;
		br_d = br_q;
		ctrl_d = ctrl_q;
		if (s_axi_awvalid && !aw_q && !b_q) begin
			aw_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_q && !b_q) begin
			w_d = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		if (aw_q && w_q && !b_q) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			b_d = 1'b1;
			br_d = RESP_OKAY;
			if (awa_q[7:2] == REG_CTRL[7:2]) begin
				if (ws_q[0]) begin
					ctrl_d = wd_q[2:0];
				end
			end else begin
				br_d = RESP_SLVERR;
			end
		end
		if (b_q && s_axi_bready) begin
			b_d = 1'b0;
		end
	end

	always_comb begin
		r_d = r_q;
		rd_d = rd_q;
		rr_d = rr_q;
		if (s_axi_arvalid && !r_q) begin
			r_d = 1'b1;
			rr_d = RESP_OKAY;
			unique case (s_axi_araddr[7:2])
				REG_CTRL[7:2]:   rd_d = {29'h0, ctrl_q};
				REG_STATUS[7:2]: rd_d = status;
				REG_WORD0[7:2]:  rd_d = word0;
				REG_WORD1[7:2]:  rd_d = word1;
				default: begin
					rd_d = 32'h0000_0000;
					rr_d = RESP_SLVERR;
				end
			endcase
		end else if (r_q && s_axi_rready) begin
			r_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			b_q <= 1'b0;
			r_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			rd_q <= 32'h0000_0000;
			br_q <= RESP_OKAY;
			rr_q <= RESP_OKAY;
			ctrl_q <= CTRL_RESET;
		end else begin
			aw_q <= aw_d;
			w_q <= w_d;
			b_q <= b_d;
			r_q <= r_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			rd_q <= rd_d;
			br_q <= br_d;
			rr_q <= rr_d;
			ctrl_q <= ctrl_d;
		end
	end

	assign s_axi_awready = !aw_q && !b_q;
	assign s_axi_wready  = !w_q && !b_q;
	assign s_axi_bvalid  = b_q;
	assign s_axi_bresp   = br_q;
	assign s_axi_arready = !r_q;
	assign s_axi_rvalid  = r_q;
	assign s_axi_rdata   = rd_q;
	assign s_axi_rresp   = rr_q;
	assign ctrl          = ctrl_q;
endmodule : mrp_axil

// file: mrp_packer.sv
// Module: top of the 16-bit mouse report packer
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module mrp_packer
	import mrp_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        left_button,
	input  wire logic        right_button,
	input  wire logic        middle_button,
	input  wire logic        back_button,
	input  wire logic        forward_button,
	input  wire logic        delta_valid,
	input  wire logic [15:0] delta_x,
	input  wire logic [15:0] delta_y,
	input  wire logic [7:0]  delta_wheel,
	input  wire logic [7:0]  horizontal_tilt_count,
	input  wire logic        poll,
	output logic             rpt_valid,
	input  wire logic        rpt_ready,
	output logic      [7:0]  rpt_data,
	output logic             rpt_last
);
	// ****************************************************************
	// Button pin synchronisers
	// ****************************************************************
	logic [4:0] btn_meta_q, btn_sync_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			btn_meta_q <= 5'h00;
			btn_sync_q <= 5'h00;
		end else begin
			btn_meta_q <= {forward_button, back_button, middle_button,
			               right_button, left_button};
			btn_sync_q <= btn_meta_q;
		end
	end

	// ****************************************************************
	// Registers and accumulation
	// ****************************************************************
	logic [2:0]  ctrl;
	logic [31:0] status, word0, word1;
	logic [15:0] acc_x, acc_y;
	logic [7:0]  acc_wheel, acc_tilt;
	logic        snap;

	mrp_axil u_regs (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.ctrl          (ctrl),
		.status        (status),
		.word0         (word0),
		.word1         (word1)
	);

	mrp_accum u_acc (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.delta_valid (delta_valid),
		.delta_x     (delta_x),
		.delta_y     (delta_y),
		.delta_wheel (delta_wheel),
		.delta_tilt  (horizontal_tilt_count),
		.snap        (snap),
		.acc_x       (acc_x),
		.acc_y       (acc_y),
		.acc_wheel   (acc_wheel),
		.acc_tilt    (acc_tilt)
	);

	// ****************************************************************
	// Report framer
	// ****************************************************************
	mrp_state_e  st_q, st_d;
	logic [7:0]  rb_q [0:6];
	logic [7:0]  rb_d [0:6];
	logic [2:0]  idx_q, idx_d, len_q, len_d;
	logic [7:0]  btn_byte;
	logic        tilt_en, five_en, armed;
	logic [15:0] sent_q, sent_d;

	assign tilt_en = ctrl[CTRL_TILT_BIT];
	assign five_en = ctrl[CTRL_FIVE_BIT];
	assign armed   = ctrl[CTRL_ARM_BIT];

	// Unused upper bits forced low so a stray pin cannot leak in
	always_comb begin
		btn_byte = {5'h00, btn_sync_q[2:0]};
		if (five_en) begin
			btn_byte = {3'h0, btn_sync_q[4:0]};
		end
	end

	// Report is frozen at the poll so the bytes of one report stay coherent
	assign snap = (st_q == ST_IDLE) && poll && armed;

	always_comb begin
		st_d = st_q;
		idx_d = idx_q;
		len_d = len_q;
		sent_d = sent_q;
		for (int i = 0; i < 7; i++) begin
			rb_d[i] = rb_q[i];
		end
		unique case (st_q)
			ST_IDLE: begin
				if (snap) begin
					st_d = ST_SEND;
					idx_d = 3'd0;
					rb_d[BYTE_BUTTONS] = btn_byte;
					rb_d[BYTE_X_LO]    = acc_x[7:0];
					rb_d[BYTE_X_HI]    = acc_x[15:8];
					rb_d[BYTE_Y_LO]    = acc_y[7:0];
					rb_d[BYTE_Y_HI]    = acc_y[15:8];
					rb_d[BYTE_WHEEL]   = acc_wheel;
					rb_d[BYTE_TILT]    = tilt_en ? acc_tilt : 8'h00;
					len_d = tilt_en ? LEN_TILT : LEN_NO_TILT;
				end
			end
			ST_SEND: begin
				if (rpt_ready) begin
					if (idx_q == len_q - 3'd1) begin
						st_d = ST_IDLE;
						sent_d = sent_q + 16'h0001;
					end else begin
						idx_d = idx_q + 3'd1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ST_IDLE;
			idx_q <= 3'd0;
			len_q <= LEN_NO_TILT;
			sent_q <= 16'h0000;
			for (int i = 0; i < 7; i++) begin
				rb_q[i] <= 8'h00;
			end
		end else begin
			st_q <= st_d;
			idx_q <= idx_d;
			len_q <= len_d;
			sent_q <= sent_d;
			for (int i = 0; i < 7; i++) begin
				rb_q[i] <= rb_d[i];
			end
		end
	end

	assign rpt_valid = (st_q == ST_SEND);
	assign rpt_data  = rpt_valid ? rb_q[idx_q] : 8'h00;
	assign rpt_last  = rpt_valid && (idx_q == len_q - 3'd1);
	assign status    = {sent_q, 8'h00, 4'h0, rpt_valid, len_q};
	assign word0     = {acc_y, acc_x};
	assign word1     = {8'h00, btn_byte, acc_tilt, acc_wheel};

	// ****************************************************************
	// Check helpers
	// ****************************************************************
	// Shadow snapshot and an own byte count, so stream checks
	// do not lean on the framer's index or byte store
	logic [2:0]  chk_cnt_q, chk_cnt_d;
	logic        chk_tilt_q, chk_tilt_d;
	logic [15:0] chk_x_q, chk_x_d, chk_y_q, chk_y_d;
	logic [7:0]  chk_b_q, chk_b_d, chk_w_q, chk_w_d, chk_t_q, chk_t_d;

	always_comb begin
		chk_cnt_d = chk_cnt_q;
		chk_tilt_d = chk_tilt_q;
		chk_x_d = chk_x_q;
		chk_y_d = chk_y_q;
		chk_b_d = chk_b_q;
		chk_w_d = chk_w_q;
		chk_t_d = chk_t_q;
		if (snap) begin
			chk_cnt_d = 3'd0;
			chk_tilt_d = tilt_en;
			chk_x_d = acc_x;
			chk_y_d = acc_y;
			chk_b_d = btn_byte;
			chk_w_d = acc_wheel;
			chk_t_d = acc_tilt;
		end else if (rpt_valid && rpt_ready) begin
			chk_cnt_d = chk_cnt_q + 3'd1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chk_cnt_q <= 3'd0;
			chk_tilt_q <= 1'b0;
			chk_x_q <= 16'h0000;
			chk_y_q <= 16'h0000;
			chk_b_q <= 8'h00;
			chk_w_q <= 8'h00;
			chk_t_q <= 8'h00;
		end else begin
			chk_cnt_q <= chk_cnt_d;
			chk_tilt_q <= chk_tilt_d;
			chk_x_q <= chk_x_d;
			chk_y_q <= chk_y_d;
			chk_b_q <= chk_b_d;
			chk_w_q <= chk_w_d;
			chk_t_q <= chk_t_d;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_start;
		snap;
	endsequence

	sequence s_handshake;
		rpt_valid && rpt_ready;
	endsequence

	sequence s_stall;
		rpt_valid && !rpt_ready;
	endsequence

	a_btn_three: assert property (@(posedge aclk) disable iff (!aresetn)
		snap && !five_en |=> rb_q[BYTE_BUTTONS][7:3] == 5'h00)
		else $error("three-button byte has high bits set");
	a_btn_five: assert property (@(posedge aclk) disable iff (!aresetn)
		snap && five_en |=> rb_q[BYTE_BUTTONS] == {3'h0, $past(btn_sync_q)})
		else $error("five-button byte mismatch");
	a_x_low: assert property (@(posedge aclk) disable iff (!aresetn)
		s_start |=> rb_q[BYTE_X_LO] == $past(acc_x[7:0]))
		else $error("x low byte mismatch");
	a_x_high: assert property (@(posedge aclk) disable iff (!aresetn)
		s_start |=> rb_q[BYTE_X_HI] == $past(acc_x[15:8]))
		else $error("x high byte mismatch");
	a_y_low: assert property (@(posedge aclk) disable iff (!aresetn)
		s_start |=> rb_q[BYTE_Y_LO] == $past(acc_y[7:0]))
		else $error("y low byte mismatch");
	a_y_high: assert property (@(posedge aclk) disable iff (!aresetn)
		s_start |=> rb_q[BYTE_Y_HI] == $past(acc_y[15:8]))
		else $error("y high byte mismatch");
	a_wheel_byte: assert property (@(posedge aclk) disable iff (!aresetn)
		s_start |=> rb_q[BYTE_WHEEL] == $past(acc_wheel))
		else $error("wheel byte mismatch");
	a_tilt_len: assert property (@(posedge aclk) disable iff (!aresetn)
		s_start ##0 tilt_en |=> len_q == LEN_TILT && rb_q[BYTE_TILT] == $past(acc_tilt))
		else $error("tilt report wrong");
	a_no_tilt: assert property (@(posedge aclk) disable iff (!aresetn)
		s_start ##0 !tilt_en |=> len_q == LEN_NO_TILT && rb_q[BYTE_TILT] == 8'h00)
		else $error("six-byte report ends wrong");
	a_acc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		snap && !delta_valid |=> acc_x == 16'h0000 && acc_y == 16'h0000)
		else $error("accumulator not cleared");
	a_hold_byte: assert property (@(posedge aclk) disable iff (!aresetn)
		s_stall |=> rpt_valid && $stable(rpt_data) && $stable(rpt_last))
		else $error("report byte changed while stalled");
	a_six_long: assert property (@(posedge aclk) disable iff (!aresetn)
		s_handshake ##0 rpt_last && !chk_tilt_q |-> chk_cnt_q == 3'd5)
		else $error("report without tilt is not six bytes");
	a_seven_long: assert property (@(posedge aclk) disable iff (!aresetn)
		s_handshake ##0 rpt_last && chk_tilt_q |-> chk_cnt_q == 3'd6)
		else $error("report with tilt is not seven bytes");
	a_out_buttons: assert property (@(posedge aclk) disable iff (!aresetn)
		rpt_valid && chk_cnt_q == 3'd0 |-> rpt_data == chk_b_q)
		else $error("button byte on the stream wrong");
	a_out_x_lo: assert property (@(posedge aclk) disable iff (!aresetn)
		rpt_valid && chk_cnt_q == 3'd1 |-> rpt_data == chk_x_q[7:0])
		else $error("x low byte on the stream wrong");
	a_out_x_hi: assert property (@(posedge aclk) disable iff (!aresetn)
		rpt_valid && chk_cnt_q == 3'd2 |-> rpt_data == chk_x_q[15:8])
		else $error("x high byte on the stream wrong");
	a_out_y_lo: assert property (@(posedge aclk) disable iff (!aresetn)
		rpt_valid && chk_cnt_q == 3'd3 |-> rpt_data == chk_y_q[7:0])
		else $error("y low byte on the stream wrong");
	a_out_y_hi: assert property (@(posedge aclk) disable iff (!aresetn)
		rpt_valid && chk_cnt_q == 3'd4 |-> rpt_data == chk_y_q[15:8])
		else $error("y high byte on the stream wrong");
	a_out_wheel: assert property (@(posedge aclk) disable iff (!aresetn)
		rpt_valid && chk_cnt_q == 3'd5 |-> rpt_data == chk_w_q)
		else $error("wheel byte on the stream wrong");
	a_out_tilt: assert property (@(posedge aclk) disable iff (!aresetn)
		rpt_valid && chk_cnt_q == 3'd6 |-> chk_tilt_q && rpt_data == chk_t_q)
		else $error("tilt byte on the stream wrong");
	a_acc_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!snap && !delta_valid |=> $stable(acc_x) && $stable(acc_y) && $stable(acc_wheel))
		else $error("accumulator moved without a delta");
endmodule : mrp_packer

// file: mrp_host.sv
// Host model: polls the report endpoint and takes bytes, stalling on request
`timescale 1ns/1ns
module mrp_host
	import mrp_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic go,
	input  wire logic slow,
	output logic      poll,
	output logic      rpt_ready
);
	// ****************************************************************
	// Poll and stall state
	// ****************************************************************
	logic stall_q;
	logic stall_d;
	logic poll_q;
	logic poll_d;

	always_comb begin
		stall_d = slow & ~stall_q;
		poll_d  = go;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stall_q <= 1'b0;
			poll_q  <= 1'b0;
		end else begin
			stall_q <= stall_d;
			poll_q  <= poll_d;
		end
	end

	// Ready drops every other cycle when slow, so each byte has to stand
	assign rpt_ready = ~stall_q;
	assign poll      = poll_q;
endmodule : mrp_host

// file: test_mrp_packer.sv
// Testbench: register access and report framing for the report packer
`timescale 1ns/1ns
module test_mrp_packer;
	import mrp_pkg::*;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        left_button = 1'b0, right_button = 1'b0, middle_button = 1'b0;
	logic        back_button = 1'b0, forward_button = 1'b0, delta_valid = 1'b0;
	logic [15:0] delta_x = 16'h0000, delta_y = 16'h0000;
	logic [7:0]  delta_wheel = 8'h00, horizontal_tilt_count = 8'h00;
	logic        poll, rpt_valid, rpt_ready, rpt_last;
	logic [7:0]  rpt_data;
	logic        go = 1'b0, slow = 1'b0;
	logic [31:0] seed = 32'h459a_8e2d;
	int          fail_count = 0;
	int          samples_checked = 0;
	logic [8:0]  exp_q[$];

	mrp_packer dut (.*);
	mrp_host host (.*);

	always #5 aclk = ~aclk;

	// ****************************************************************
	// Tasks
	// ****************************************************************
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge aclk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid & s_axi_bready;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end
		check({30'h0, r}, {30'h0, er});
	endtask : axw

	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ar, rv;
		logic [1:0] r;
		logic [31:0] d;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		rv = 1'b0;
		while (!rv) begin
			@(negedge aclk);
			ar = s_axi_arvalid & s_axi_arready;
			rv = s_axi_rvalid & s_axi_rready;
			r = s_axi_rresp;
			d = s_axi_rdata;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (rv) s_axi_rready <= 1'b0;
		end
		check({30'h0, r}, {30'h0, er});
		check(d, ed);
	endtask : axr

	task automatic pulse_go();
		@(posedge aclk);
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
	endtask : pulse_go

	task automatic report(input logic five, input logic tilt);
		logic [15:0] x, y, dx, dy;
		logic [7:0]  z, t, dz, dt, bt;
		int n;
		slow <= five;
		axw(REG_CTRL, {29'h0, 1'b1, five, tilt}, RESP_OKAY);
		seed = lfsr_next(seed);
		{forward_button, back_button, middle_button, right_button, left_button} <= seed[4:0];
		bt = five ? {3'h0, seed[4:0]} : {5'h00, seed[2:0]};
		x = 16'h0000;
		y = 16'h0000;
		z = 8'h00;
		t = 8'h00;
		// Small deltas so two of them never saturate
		repeat (2) begin
			seed = lfsr_next(seed);
			dx = {{3{seed[12]}}, seed[12:0]};
			dy = {{3{seed[28]}}, seed[28:16]};
			dz = {{5{seed[15]}}, seed[15:13]};
			dt = {{5{seed[31]}}, seed[31:29]};
			@(posedge aclk);
			delta_valid <= 1'b1;
			delta_x <= dx;
			delta_y <= dy;
			delta_wheel <= dz;
			horizontal_tilt_count <= dt;
			x = x + dx;
			y = y + dy;
			z = z + dz;
			t = t + dt;
		end
		@(posedge aclk);
		delta_valid <= 1'b0;
		tick(3);
		axr(REG_WORD0, {y, x}, RESP_OKAY);
		axr(REG_WORD1, {8'h00, bt, t, z}, RESP_OKAY);
		exp_q.push_back({1'b0, bt});
		exp_q.push_back({1'b0, x[7:0]});
		exp_q.push_back({1'b0, x[15:8]});
		exp_q.push_back({1'b0, y[7:0]});
		exp_q.push_back({1'b0, y[15:8]});
		exp_q.push_back({~tilt, z});
		if (tilt) exp_q.push_back({1'b1, t});
		pulse_go();
		// A second poll in mid-report must not start another one
		if (five) begin
			tick(3);
			pulse_go();
		end
		n = 0;
		while (exp_q.size() != 0 && n < 200) begin
			@(posedge aclk);
			n++;
		end
		tick(4);
		check(exp_q.size(), 32'h0000_0000);
		axr(REG_WORD0, 32'h0000_0000, RESP_OKAY);
		$display("Test report five=%0d tilt=%0d done", five, tilt);
	endtask : report

	// ****************************************************************
	// Monitor, watchdog and main sequence
	// ****************************************************************
	always @(negedge aclk) begin
		if (aresetn && rpt_valid === 1'b1 && rpt_ready === 1'b1) begin
			if (exp_q.size() == 0) check({23'h0, rpt_last, rpt_data}, 32'h0000_0fff);
			else check({23'h0, rpt_last, rpt_data}, {23'h0, exp_q.pop_front()});
		end
	end

	initial begin
		repeat (5000) @(posedge aclk);
		fail_count++;
		give_verdict();
	end

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
		axr(REG_STATUS, {29'h0, LEN_NO_TILT}, RESP_OKAY);
		axr(8'h10, 32'h0000_0000, RESP_SLVERR);
		axw(REG_STATUS, 32'hffff_ffff, RESP_SLVERR);
		axr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
		// Not armed: a poll must produce no bytes
		pulse_go();
		tick(10);
		$display("Test registers and idle poll done");
		for (int c = 0; c < 4; c++) begin
			report(c[1], c[0]);
		end
		axr(REG_STATUS, {16'h0004, 13'h0000, LEN_TILT}, RESP_OKAY);
		tick(5);
		give_verdict();
	end
endmodule : test_mrp_packer
